// file: dram_host_pkg.sv
package dram_host_pkg;

	// Clock rate
	localparam int CLK_PERIOD_NS = 8;

	// Address fields
	localparam int ADDR_W      = 8;
	localparam int CELL_ADDR_W = 16;
	localparam int REFRESH_W   = 7;
	localparam int COLUMNS     = 256;

	// Times in their own units
	localparam int POWERUP_WAIT_US    = 100;
	localparam int IDLE_LIMIT_MS      = 2;
	localparam int WAKE_CYCLES        = 8;
	localparam int REFRESH_GAP_NS     = 15600;
	localparam int ROW_ACTIVE_MAX_NS  = 10000;
	localparam int COL_OVERLAP_NS     = 10;
	localparam int ROW_ACTIVE_MIN_NS  = 120;
	localparam int COL_ACTIVE_MIN_NS  = 60;
	localparam int ROW_PRECHARGE_NS   = 100;
	localparam int COL_PRECHARGE_NS   = 60;
	localparam int ROW_TO_COL_NS      = 25;
	localparam int ROW_ADDR_HOLD_NS   = 25;
	localparam int WRITE_LEAD_NS      = 55;
	localparam int ACCESS_FROM_ROW_NS = 150;
	localparam int ACCESS_FROM_COL_NS = 100;

	// Cycle counts: least times round up, longest round down
	localparam int POWERUP_CYC  = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_CYC     = (IDLE_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC  = REFRESH_GAP_NS / CLK_PERIOD_NS;
	localparam int ROW_MAX_CYC  = ROW_ACTIVE_MAX_NS / CLK_PERIOD_NS;
	localparam int OVERLAP_CYC  = (COL_OVERLAP_NS / CLK_PERIOD_NS) < 1 ? 1
		: COL_OVERLAP_NS / CLK_PERIOD_NS;
	localparam int RAS_MIN_CYC  = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_MIN_CYC  = (COL_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC       = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CP_CYC       = (COL_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCD_CYC      = (ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAH_CYC      = (ROW_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WL_CYC       = (WRITE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAC_CYC      = (ACCESS_FROM_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAC_CYC      = (ACCESS_FROM_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Access kinds requested by the user
	typedef enum logic [1:0]
	{
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_RMW   = 2'h2
	} op_e;

endpackage : dram_host_pkg

// file: interval_timer.sv
`timescale 1ns/1ns

// Down counter that flags expiry, holds at zero and reloads on request
module interval_timer
#(
	parameter int COUNT = 16,
	parameter int W     = 32
)
(
	input  wire logic core_clk_in,
	input  wire logic nrst_in,
	input  wire logic en_in,
	input  wire logic reload_in,
	output logic      expired_out
);

	logic [W-1:0] cnt_q;

	// Count down, hold at zero until reloaded
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cnt_q <= W'(COUNT);
		else if (en_in)
		begin
			if (reload_in)
				cnt_q <= W'(COUNT);
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign expired_out = (cnt_q == '0);

endmodule : interval_timer

// file: dram_host.sv
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: After power-up wait 100 us, then eight row-strobe cycles before accesses.
// R2: After more than 2 ms idle, repeat the eight-cycle wake-up.
// R3: Row strobe high puts the memory in standby; data is kept.
// R4: Row field latched on row fall, column field on column fall.
// R5: Refresh presents a 7-bit row; the top address line is ignored.
// R6: Read drives row address, drops row strobe, then column strobe in window.
// R7: Column strobe late means access is timed from the column edge.
// R8: Memory ignores column strobe until its internal row strobe is active.
// R9: Strobes held for minimum active times; row precharge kept between cycles.
// R10: Read data is valid only while column strobe stays low.
// R11: Column strobe may overlap next cycle by at most 10 ns.
// R12: Write strobe stays high across the column strobe in reads.
// R13: Write strobe low before column fall makes an early write.
// R14: Both strobes stay low for their write lead times after write strobe.
// R15: Late write still keeps row strobe within 10 us.
// R16: Early write keeps memory output off; shared buses use early writes.
// R17: Read-modify-write reads first, then lowers write strobe with new data.
// R18: Read-while-write lowers write strobe after minimum delays, data still read.
// R19: Page mode holds row strobe while cycling columns, within 10 us.
// R20: Page starts with a full cycle, then column cycles of any kind.
// R21: Refresh every row within 15.6 us; any access refreshes its row. The code refreshes one row per 15.6 us, so each row about every 2 ms.
// R22: Refresh latches row with row strobe only; column strobe stays high.
// R23: A 7-bit refresh counter advances; refresh beats pending accesses.
//////////////////////////////////////////////////////////////////////////////

module dram_host
	import dram_host_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int IDLE_CYCLES    = IDLE_CYC,
	parameter int REFRESH_CYCLES = REFRESH_CYC,
	parameter int ROW_MAX_CYCLES = ROW_MAX_CYC
)
(
	input  wire logic                   core_clk_in,
	input  wire logic                   nrst_in,
	input  wire logic                   clk_en_in,
	input  wire logic                   req_valid_in,
	input  wire logic [1:0]             req_op_in,
	input  wire logic [CELL_ADDR_W-1:0] req_addr_in,
	input  wire logic                   req_wdata_in,
	input  wire logic                   req_page_in,
	output logic                        req_ready_out,
	output logic                        rsp_valid_out,
	output logic                        rsp_rdata_out,
	output logic                        init_done_out,
	output logic                        row_strobe_n_out,
	output logic                        col_strobe_n_out,
	output logic                        write_strobe_n_out,
	output logic [ADDR_W-1:0]           addr_out,
	output logic                        din_out,
	input  wire logic                   dout_in
);

	localparam int CW = 16;

	typedef enum logic [3:0]
	{
		ST_POWERUP = 4'h0,
		ST_PRECH   = 4'h1,
		ST_IDLE    = 4'h2,
		ST_ROW     = 4'h3,
		ST_COLADR  = 4'h4,
		ST_COL     = 4'h5,
		ST_LATEW   = 4'h6,
		ST_COLEND  = 4'h7,
		ST_PAGE    = 4'h8,
		ST_CPRE    = 4'h9,
		ST_REFRESH = 4'hA
	} state_e;

	typedef struct packed
	{
		state_e                  st;
		logic [CW-1:0]           cnt;
		logic [CW-1:0]           row_cnt;
		logic [3:0]              wake;
		logic                    waking;
		logic [REFRESH_W-1:0]    rfsh_row;
		logic                    ras_n;
		logic                    cas_n;
		logic                    we_n;
		logic [ADDR_W-1:0]       addr;
		logic                    din;
		logic [1:0]              op;
		logic [ADDR_W-1:0]       row;
		logic [ADDR_W-1:0]       col;
		logic                    page;
		logic                    in_page;
		logic                    rvalid;
		logic                    rdata;
		logic                    ready;
		logic                    dsync1;
		logic                    dsync2;
	} regs_s;

	regs_s r_q;
	regs_s r_d;

	logic rfsh_due;
	logic idle_long;
	logic rfsh_reload;
	logic idle_reload;

	//////////////////////////////////////////////////////////////////////////
	// Refresh interval and idle watchdog

	interval_timer #(.COUNT(REFRESH_CYCLES), .W(32)) u_rfsh_timer
	(
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.en_in       (clk_en_in),
		.reload_in   (rfsh_reload),
		.expired_out (rfsh_due)
	);

	// Idle watchdog reloaded by any row-strobe activity
	interval_timer #(.COUNT(IDLE_CYCLES), .W(32)) u_idle_timer
	(
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.en_in       (clk_en_in),
		.reload_in   (idle_reload),
		.expired_out (idle_long)
	);

	assign rfsh_reload = (r_q.st == ST_REFRESH) && (r_q.cnt == '0); // R21
	assign idle_reload = !r_q.ras_n; // R2

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb
	begin
		r_d = r_q;
		r_d.rvalid = 1'b0;
		r_d.ready  = 1'b0;
		r_d.dsync1 = dout_in;
		r_d.dsync2 = r_q.dsync1;
		if (r_q.cnt != '0)
			r_d.cnt = r_q.cnt - 1'b1;
		if (!r_q.ras_n)
			r_d.row_cnt = r_q.row_cnt + 1'b1;
		else
			r_d.row_cnt = '0;

		case (r_q.st)
			// Power-up pause with strobes high
			ST_POWERUP:
			begin
				if (r_q.cnt == '0)
				begin
					r_d.waking = 1'b1; // R1
					r_d.wake   = 4'(WAKE_CYCLES);
					r_d.st     = ST_PRECH;
					r_d.cnt    = CW'(RP_CYC);
				end
			end

			// Row precharge between cycles; wake cycles run here too
			ST_PRECH:
			begin
				r_d.ras_n = 1'b1; // R9
				r_d.cas_n = 1'b1;
				r_d.we_n  = 1'b1;
				if (r_q.cnt == '0)
				begin
					if (r_q.waking && r_q.wake != '0)
					begin
						r_d.wake  = r_q.wake - 1'b1; // R1 R2
						r_d.st    = ST_REFRESH;
						r_d.addr  = {1'b0, r_q.rfsh_row};
						r_d.ras_n = 1'b0;
						r_d.cnt   = CW'(RAS_MIN_CYC);
					end
					else
					begin
						r_d.waking = 1'b0;
						r_d.st     = ST_IDLE;
					end
				end
			end

			// Wait for work; wake-up check first, then refresh
			ST_IDLE:
			begin
				if (idle_long)
				begin
					r_d.waking = 1'b1; // R2
					r_d.wake   = 4'(WAKE_CYCLES);
					r_d.st     = ST_PRECH;
				end
				else if (rfsh_due)
				begin
					r_d.addr  = {1'b0, r_q.rfsh_row}; // R5 R23
					r_d.ras_n = 1'b0; // R22
					r_d.st    = ST_REFRESH;
					r_d.cnt   = CW'(RAS_MIN_CYC);
				end
				else if (req_valid_in)
				begin
					r_d.ready = 1'b1;
					r_d.op    = req_op_in;
					r_d.row   = req_addr_in[CELL_ADDR_W-1:ADDR_W];
					r_d.col   = req_addr_in[ADDR_W-1:0];
					r_d.din   = req_wdata_in;
					r_d.page  = req_page_in;
					r_d.in_page = 1'b0;
					r_d.addr  = req_addr_in[CELL_ADDR_W-1:ADDR_W]; // R4 R6
					r_d.st    = ST_ROW;
				end
			end

			// Row address settled, lower row strobe, hold row address
			ST_ROW:
			begin
				r_d.ras_n = 1'b0; // R6
				r_d.st    = ST_COLADR;
				r_d.cnt   = CW'(RAH_CYC > RCD_CYC ? RAH_CYC : RCD_CYC);
			end

			// Switch to column address, choose early write
			ST_COLADR:
			begin
				if (r_q.cnt == '0)
				begin
					r_d.addr = r_q.col; // R4 R8
					if (r_q.op == 2'(OP_WRITE))
						r_d.we_n = 1'b0; // R13 R16
					else
						r_d.we_n = 1'b1; // R12
					r_d.st = ST_COL;
				end
			end

			// Lower column strobe; address and write setup met a cycle ago
			ST_COL:
			begin
				r_d.cas_n = 1'b0; // R6 R4
				r_d.st    = ST_LATEW;
				if (r_q.op == 2'(OP_WRITE))
					r_d.cnt = CW'(WL_CYC > CAS_MIN_CYC ? WL_CYC : CAS_MIN_CYC); // R14
				else
					r_d.cnt = CW'((r_q.in_page ? CAC_CYC : RAC_CYC) + 2); // R7
			end

			// Wait for data (read) or lead time (write); late strobe for RMW
			ST_LATEW:
			begin
				if (r_q.cnt == '0)
				begin
					if (r_q.op == 2'(OP_RMW) && r_q.we_n)
					begin
						r_d.rdata  = r_q.dsync2; // R17 R10
						r_d.rvalid = 1'b1;
						r_d.we_n   = 1'b0; // R17 R18
						r_d.cnt    = CW'(WL_CYC); // R14
					end
					else
					begin
						if (r_q.op == 2'(OP_READ))
						begin
							r_d.rdata  = r_q.dsync2; // R10
							r_d.rvalid = 1'b1;
						end
						r_d.st = ST_COLEND;
					end
				end
			end

			// Release column strobe, then page or close the row
			ST_COLEND:
			begin
				r_d.cas_n = 1'b1; // R11
				r_d.we_n  = 1'b1; // R12
				if (r_q.page && r_q.row_cnt < CW'(ROW_MAX_CYCLES - 64) && !rfsh_due)
					r_d.st = ST_PAGE; // R19 R15
				else
				begin
					r_d.st  = ST_PRECH;
					r_d.cnt = CW'(r_q.row_cnt < CW'(RAS_MIN_CYC) ? RP_CYC + RAS_MIN_CYC : RP_CYC);
					r_d.ras_n = r_q.row_cnt < CW'(RAS_MIN_CYC) ? 1'b0 : 1'b1; // R9
				end
			end

			// Row open: take the next column access of any kind
			ST_PAGE:
			begin
				if (rfsh_due || r_q.row_cnt >= CW'(ROW_MAX_CYCLES - 64) || !req_valid_in ||
					req_addr_in[CELL_ADDR_W-1:ADDR_W] != r_q.row)
				begin
					r_d.ras_n = 1'b1; // R23 R19
					r_d.st    = ST_PRECH;
					r_d.cnt   = CW'(RP_CYC);
				end
				else
				begin
					r_d.ready = 1'b1; // R20
					r_d.op    = req_op_in;
					r_d.col   = req_addr_in[ADDR_W-1:0];
					r_d.din   = req_wdata_in;
					r_d.page  = req_page_in;
					r_d.in_page = 1'b1;
					r_d.st    = ST_CPRE;
					r_d.cnt   = CW'(CP_CYC);
				end
			end

			// Column precharge before the next page access
			ST_CPRE:
			begin
				if (r_q.cnt <= CW'(1))
					r_d.st = ST_COLADR; // R19
			end

			// Row-strobe-only refresh cycle
			ST_REFRESH:
			begin
				r_d.cas_n = 1'b1; // R22
				if (r_q.cnt == '0)
				begin
					r_d.ras_n    = 1'b1;
					r_d.rfsh_row = r_q.rfsh_row + 1'b1; // R23
					r_d.st       = ST_PRECH;
					r_d.cnt      = CW'(RP_CYC);
				end
			end

			default:
			begin
				r_d.st = ST_PRECH;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			r_q       <= '0;
			r_q.st    <= ST_POWERUP;
			r_q.cnt   <= CW'(POWERUP_CYCLES); // R1
			r_q.ras_n <= 1'b1; // R3
			r_q.cas_n <= 1'b1;
			r_q.we_n  <= 1'b1;
		end
		else if (clk_en_in)
			r_q <= r_d;
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs

	assign req_ready_out      = r_q.ready;
	assign rsp_valid_out      = r_q.rvalid;
	assign rsp_rdata_out      = r_q.rdata;
	assign init_done_out      = (r_q.st != ST_POWERUP) && !r_q.waking;
	assign row_strobe_n_out   = r_q.ras_n;
	assign col_strobe_n_out   = r_q.cas_n;
	assign write_strobe_n_out = r_q.we_n;
	assign addr_out           = r_q.addr;
	assign din_out            = r_q.din;

endmodule : dram_host

// file: dram_host_sva.sv
`timescale 1ns/1ns

// Timing checks on the strobe pins of the controller
module dram_host_sva
	import dram_host_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int ROW_MAX_CYCLES = ROW_MAX_CYC
)
(
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	input  wire logic              init_done_out,
	input  wire logic              row_strobe_n_out,
	input  wire logic              col_strobe_n_out,
	input  wire logic              write_strobe_n_out,
	input  wire logic [ADDR_W-1:0] addr_out
);
	int since_q;
	int rlo_q;
	int rhi_q;

	// Cycles since reset, row strobe low and high run lengths
	always_ff @(posedge core_clk_in or negedge nrst_in)
		if (!nrst_in)
		begin
			since_q <= 0;
			rlo_q   <= 0;
			rhi_q   <= 0;
		end
		else
		begin
			since_q <= since_q + 1;
			rlo_q   <= row_strobe_n_out ? 0 : rlo_q + 1;
			rhi_q   <= row_strobe_n_out ? rhi_q + 1 : 0;
		end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// Row strobe release and row strobe drop
	sequence row_close;
		$rose(row_strobe_n_out);
	endsequence
	sequence row_open;
		$fell(row_strobe_n_out);
	endsequence

	a_pause_row_high: assert property (since_q < POWERUP_CYCLES |-> row_strobe_n_out)
		else $error("row strobe low in power-up pause");
	a_init_col_idle: assert property (!init_done_out |-> col_strobe_n_out)
		else $error("column strobe low before init done");
	a_col_after_row: assert property ($fell(col_strobe_n_out)
		|-> !$past(row_strobe_n_out, RCD_CYC))
		else $error("column strobe too early after row");
	a_row_active_min: assert property (row_close |-> rlo_q >= RAS_MIN_CYC)
		else $error("row strobe active too short");
	a_row_active_max: assert property (rlo_q <= ROW_MAX_CYCLES)
		else $error("row strobe active too long");
	a_row_precharge: assert property (row_open |-> rhi_q >= RP_CYC)
		else $error("row precharge too short");
	a_write_lead: assert property ($rose(col_strobe_n_out) && !$past(write_strobe_n_out)
		|-> !$past(write_strobe_n_out, WL_CYC))
		else $error("write lead time too short");
	a_refresh_top_low: assert property ((row_open and !init_done_out)
		|-> !addr_out[ADDR_W-1])
		else $error("top address line set in refresh");
endmodule : dram_host_sva

bind dram_host dram_host_sva #(
	.POWERUP_CYCLES(POWERUP_CYCLES),
	.ROW_MAX_CYCLES(ROW_MAX_CYCLES)
) dram_host_sva_inst (
	.core_clk_in,
	.nrst_in,
	.init_done_out,
	.row_strobe_n_out,
	.col_strobe_n_out,
	.write_strobe_n_out,
	.addr_out
);

// file: dram_cell_model.sv
`timescale 1ns/1ns

// Behavioural 64K x 1 memory driven by its strobes
module dram_cell_model
	import dram_host_pkg::*;
(
	input  wire logic              row_strobe_n_in,
	input  wire logic              col_strobe_n_in,
	input  wire logic              write_strobe_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              din_in,
	output logic                   dout_out
);
	logic              mem [COLUMNS*COLUMNS];
	logic [ADDR_W-1:0] row_q;
	logic [ADDR_W-1:0] col_q;
	logic              act = 1'b0;
	logic              early = 1'b0;
	logic              rd = 1'b0;
	logic              vis = 1'b0;
	time               t_row = 0;

	// Row latch; row strobe high is standby, cells kept
	always @(row_strobe_n_in)
	begin
		act = !row_strobe_n_in;
		if (act)
			t_row = $time;
		if (act)
			row_q = addr_in;
	end

	// Column latch, then early write or delayed read
	always @(negedge col_strobe_n_in)
		if (act)
		begin
			col_q = addr_in;
			early = !write_strobe_n_in;
			rd = mem[{row_q, col_q}];
			#1;
			if (early)
				mem[{row_q, col_q}] = din_in;
			else
			begin
				#(ACCESS_FROM_COL_NS - 1);
				if ($time < t_row + ACCESS_FROM_ROW_NS)
					#(t_row + ACCESS_FROM_ROW_NS - $time);
				vis = !col_strobe_n_in;
			end
		end

	// Late write strobe stores data; read bit stays out
	always @(negedge write_strobe_n_in)
		if (act && !col_strobe_n_in && !early)
		begin
			#1;
			mem[{row_q, col_q}] = din_in;
		end

	// Output off when column strobe is released
	always @(posedge col_strobe_n_in)
		vis = 1'b0;

	// Undriven output shows the inverse of the last bit
	assign dout_out = vis ? rd : !rd;
endmodule : dram_cell_model

// file: dram_host_tb.sv
`timescale 1ns/1ns

module dram_host_tb
	import dram_host_pkg::*;
;
	typedef struct packed {logic [1:0] op; logic [15:0] a; logic wd; logic pg; logic ex;} row_s;
	// Access list: kind, address, write bit, page, expected read bit
	localparam row_s ROWS [11] = '{
		{2'h1, 16'h0000, 3'b100}, {2'h1, 16'hFFFF, 3'b000}, {2'h0, 16'h0000, 3'b001},
		{2'h0, 16'hFFFF, 3'b000}, {2'h2, 16'hFFFF, 3'b100}, {2'h0, 16'hFFFF, 3'b001},
		{2'h1, 16'hAB01, 3'b110}, {2'h1, 16'hAB02, 3'b010}, {2'h0, 16'hAB01, 3'b011},
		{2'h2, 16'hAB02, 3'b110}, {2'h0, 16'hAB02, 3'b001}};
	logic        core_clk_in = 1'b0;
	logic        nrst_in, clk_en_in, req_valid_in, req_wdata_in, req_page_in;
	logic [1:0]  req_op_in;
	logic [15:0] req_addr_in;
	logic        req_ready_out, rsp_valid_out, rsp_rdata_out, init_done_out;
	logic        row_strobe_n_out, col_strobe_n_out, write_strobe_n_out, din_out, dout_in;
	logic [7:0]  addr_out;
	logic [6:0]  rf_last, rf_prev;
	int          mismatches, checks, rf_cnt, n0;
	logic        mon = 1'b0;

	dram_host #(.POWERUP_CYCLES(50), .IDLE_CYCLES(400), .REFRESH_CYCLES(200)) dram_host_inst (
		.core_clk_in, .nrst_in, .clk_en_in, .req_valid_in, .req_op_in, .req_addr_in,
		.req_wdata_in, .req_page_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out,
		.init_done_out, .row_strobe_n_out, .col_strobe_n_out, .write_strobe_n_out,
		.addr_out, .din_out, .dout_in);
	dram_cell_model dram_cell_model_inst (.row_strobe_n_in(row_strobe_n_out),
		.col_strobe_n_in(col_strobe_n_out), .write_strobe_n_in(write_strobe_n_out),
		.addr_in(addr_out), .din_in(din_out), .dout_out(dout_in));

	always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;

	// Idle row drops are refresh cycles
	always @(negedge row_strobe_n_out)
		if (mon)
		begin
			#1;
			rf_cnt++;
			rf_prev = rf_last;
			rf_last = addr_out[6:0];
			check_bit(addr_out[7], 1'b0);
		end

	task automatic check_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic wait_init();
		int n;
		n = 0;
		while (init_done_out !== 1'b1 && n < 4000)
		begin
			@(negedge core_clk_in);
			n++;
		end
		check_bit(init_done_out, 1'b1);
	endtask : wait_init

	task automatic do_req(input row_s r);
		int n;
		{req_op_in, req_addr_in, req_wdata_in, req_page_in} = r[20:1];
		req_valid_in = 1'b1;
		n = 0;
		@(negedge core_clk_in);
		while (req_ready_out !== 1'b1 && n < 600)
		begin
			@(negedge core_clk_in);
			n++;
		end
		req_valid_in = 1'b0;
		check_bit(req_ready_out, 1'b1);
		if (r.op != OP_WRITE)
		begin
			n = 0;
			while (rsp_valid_out !== 1'b1 && n < 200)
			begin
				@(negedge core_clk_in);
				n++;
			end
			check_bit(rsp_valid_out & (rsp_rdata_out === r.ex), 1'b1);
		end
		else
			@(negedge core_clk_in);
	endtask : do_req

	task complete_run;
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// Watchdog on a hung sequence
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		mismatches++;
		complete_run();
	end

	initial
	begin
		{nrst_in, clk_en_in, req_valid_in, req_op_in, req_addr_in} = {2'b01, 19'h0};
		{req_wdata_in, req_page_in, mismatches, checks} = '0;
		repeat (3) @(negedge core_clk_in);
		check_bit(row_strobe_n_out & col_strobe_n_out & (addr_out === 8'h00), 1'b1);
		nrst_in = 1'b1;
		wait_init();
		foreach (ROWS[i]) do_req(ROWS[i]);
		// Idle: refresh rows advance one at a time
		rf_cnt = 0;
		mon = 1'b1;
		repeat (450) @(negedge core_clk_in);
		check_bit(rf_cnt >= 2, 1'b1);
		check_bit(rf_last === rf_prev + 7'h01, 1'b1);
		// Clock enable low freezes refresh
		n0 = rf_cnt;
		clk_en_in = 1'b0;
		repeat (300) @(negedge core_clk_in);
		check_bit(rf_cnt == n0, 1'b1);
		clk_en_in = 1'b1;
		mon = 1'b0;
		// Reset in mid-access, then stored data must survive
		{req_op_in, req_addr_in, req_valid_in} = {2'h0, 16'hAB01, 1'b1};
		repeat (8) @(negedge core_clk_in);
		nrst_in = 1'b0;
		#1;
		check_bit(row_strobe_n_out & col_strobe_n_out & write_strobe_n_out, 1'b1);
		check_bit(init_done_out, 1'b0);
		req_valid_in = 1'b0;
		@(negedge core_clk_in);
		nrst_in = 1'b1;
		wait_init();
		do_req(ROWS[8]);
		complete_run();
	end
endmodule : dram_host_tb
